// >>> hw/sbr_addr_strap.sv
// Identity strap capture for the status reporter.
// Assumes the address-select level is stable at reset release.
`timescale 1ns/1ps
module sbr_addr_strap (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_addr_sel,
  output sbr_pkg::sbr_cnt_t o_slot_cyc,
  output logic [1:0] o_device_id
);
  import sbr_pkg::*;

  logic taken;          // Strap already caught
  logic next_taken;
  sbr_cnt_t next_slot;
  logic [1:0] next_id;

  // Catch the strap once, on the first edge after release
  always_comb begin
    next_taken = 1'b1;
    next_slot = o_slot_cyc;
    next_id = o_device_id;
    if (!taken) begin
      case (i_addr_sel)
        ADDR_LOW_SUPPLY: begin
          next_id = ID_ONE;
          next_slot = sbr_cnt_t'(SLOT1_CYC - 1);
        end
        ADDR_SIG_RETURN: begin
          next_id = ID_THREE;
          next_slot = sbr_cnt_t'(SLOT3_CYC - 1);
        end
        default: begin
          // Floating pin, and any undecodable level
          next_id = ID_TWO;
          next_slot = sbr_cnt_t'(SLOT2_CYC - 1);
        end
      endcase
    end
  end

  // Constant reset values only; the strap is caught after release
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      taken <= 1'b0;
      o_slot_cyc <= sbr_cnt_t'(SLOT2_CYC - 1);
      o_device_id <= ID_TWO;
    end else begin
      taken <= next_taken;
      o_slot_cyc <= next_slot;
      o_device_id <= next_id;
    end
  end

endmodule : sbr_addr_strap

// >>> hw/sbr_low_meter.sv
// Measures host low pulses on the shared line and decodes commands.
// Assumes it is only enabled while this device leaves the line alone.
`timescale 1ns/1ps
module sbr_low_meter #(
  parameter int unsigned P_QUERY_CYC = sbr_pkg::QUERY_CYC,
  parameter int unsigned P_CLEAR_CYC = sbr_pkg::CLEAR_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_line,
  input wire logic i_enable,
  output logic o_query,
  output logic o_clear
);
  import sbr_pkg::*;

  sbr_cnt_t low_cnt;    // Cycles the line has been low
  sbr_cnt_t next_cnt;
  logic next_query;
  logic next_clear;

  // Decide on the rising edge, so a clear is never taken for a query
  always_comb begin
    next_cnt = low_cnt;
    next_query = 1'b0;
    next_clear = 1'b0;
    if (!i_enable) begin
      next_cnt = '0;
    end else if (!i_line) begin
      // Saturate at the clear length
      if (low_cnt < sbr_cnt_t'(P_CLEAR_CYC)) begin
        next_cnt = low_cnt + sbr_cnt_t'(1);
      end
    end else begin
      if (low_cnt >= sbr_cnt_t'(P_CLEAR_CYC)) begin
        next_clear = 1'b1;
      end else if (low_cnt >= sbr_cnt_t'(P_QUERY_CYC)) begin
        next_query = 1'b1;
      end
      next_cnt = '0;
    end
  end

  // Registered one-cycle command pulses
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt <= '0;
      o_query <= 1'b0;
      o_clear <= 1'b0;
    end else begin
      low_cnt <= next_cnt;
      o_query <= next_query;
      o_clear <= next_clear;
    end
  end

endmodule : sbr_low_meter

// >>> hw/sbr_status_reporter.sv
// Single-wire open-drain status reporter: arbitration, frame send, commands.
// Assumes i_line is the resolved line level, synchronous to i_clk.
//
// Functional notes
// - Frame is seven status bits plus parity
// - Parity makes total count of ones odd
// - Bit: released high 40/10 us, low 10 us
// - Bits 0-2 carry system state code
// - Bits 3-4 carry device warning/shutdown code
// - Bits 5,6 flag low/high-side over-current
// - All-zero word reports ready and query answer; code sends live status for both
// - Clearing of faults is reported too
// - Identity and slot from address-select strap
// - On change, snapshot status and start update
// - Start only after 80 us bus idle
// - Drive low for slot, release, check high
// - Line still low means lost; retry
// - Stay off bus 160 us after frame
// - Each update once; skip shutdown clearing
// - Only pull low or release the line
// - Host 160 us low asks for status
// - Host 320 us low clears, back to power-up
`timescale 1ns/1ps
module sbr_status_reporter #(
  parameter int unsigned P_HOLDOFF_CYC = sbr_pkg::HOLDOFF_CYC,
  parameter int unsigned P_QUERY_CYC = sbr_pkg::QUERY_CYC,
  parameter int unsigned P_CLEAR_CYC = sbr_pkg::CLEAR_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_line,
  output logic o_line_o,
  output logic o_line_oe_n,
  input wire logic [1:0] i_addr_sel,
  input wire sbr_pkg::sbr_status_t i_status,
  input wire logic i_powerup_ok,
  output logic o_mission,
  output logic o_clear_pulse,
  output logic o_busy,
  output logic [7:0] o_last_frame,
  output logic [1:0] o_device_id
);
  import sbr_pkg::*;

  // Strap and command decode
  sbr_cnt_t slot_cyc;   // Own arbitration slot, less one
  logic query_seen;     // Host status query pulse
  logic clear_seen;     // Host latch clear pulse
  logic listen;         // Line is ours to measure

  // Reporter state
  sbr_state_t state;
  sbr_state_t next_state;
  sbr_cnt_t cnt;        // Down-counter of the current interval
  sbr_cnt_t next_cnt;
  logic [2:0] bit_idx;  // Frame bit on the line
  logic [2:0] next_bit_idx;
  logic [7:0] tx_frame; // Transmit register
  logic [7:0] next_tx_frame;
  logic pending;        // A frame waits to be sent
  logic next_pending;
  logic late;           // Change seen while a frame was on the line
  logic next_late;
  sbr_status_t snap;    // Status last seen, for change detection
  sbr_status_t next_snap;
  logic next_mission;
  logic next_clear_pulse;
  logic next_oe_n;
  logic [7:0] next_last_frame;

  // Line watch
  sbr_cnt_t idle_cnt;   // Cycles the line has been high, saturating
  sbr_cnt_t next_idle_cnt;

  // Events
  logic changed;
  logic reportable;
  logic sending;
  logic event_now;

  // Identity strap
  sbr_addr_strap u_strap (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr_sel(i_addr_sel),
    .o_slot_cyc(slot_cyc),
    .o_device_id(o_device_id)
  );

  // Host pulse measurement
  sbr_low_meter #(
    .P_QUERY_CYC(P_QUERY_CYC),
    .P_CLEAR_CYC(P_CLEAR_CYC)
  ) u_meter (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_line(i_line),
    .i_enable(listen),
    .o_query(query_seen),
    .o_clear(clear_seen)
  );

  // Our own low drive must not be read as a host command
  assign listen = (state == ST_POWERUP) || (state == ST_HOLDOFF) || (state == ST_WAIT);
  assign sending = (state == ST_ARB) || (state == ST_CHECK) || (state == ST_BITHI)
                   || (state == ST_BITLO);

  // Any difference counts, set or clear, except a shutdown going away
  assign changed = (i_status != snap);
  assign reportable = changed && !((snap.dev == DEV_LS_SHUTDOWN) && (i_status.dev == DEV_NONE)
                      && (i_status.sys == snap.sys) && (i_status.ls_oc == snap.ls_oc)
                      && (i_status.hs_oc == snap.hs_oc));

  // Change, query answer or power-up ready word
  assign event_now = (o_mission && (reportable || query_seen))
                     || ((state == ST_POWERUP) && i_powerup_ok);

  // Only ever pull low: the data pin is tied low, the enable does the work
  assign o_line_o = 1'b0;
  assign o_busy = sending;

  // Idle-high measurement of the shared line
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (!i_line) begin
      next_idle_cnt = '0;
    end else if (idle_cnt < sbr_cnt_t'(BUS_IDLE_CYC)) begin
      next_idle_cnt = idle_cnt + sbr_cnt_t'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end

  // Reporter next-state logic
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_tx_frame = tx_frame;
    next_pending = pending;
    next_late = late;
    next_snap = i_status;
    next_mission = o_mission;
    next_clear_pulse = 1'b0;
    next_last_frame = o_last_frame;
    // Snapshot only when the frame on the line cannot be disturbed
    if (event_now) begin
      if (sending) begin
        next_late = 1'b1;
      end else begin
        next_tx_frame = build_frame(i_status);
        next_pending = 1'b1;
      end
    end
    case (state)
      ST_POWERUP: begin
        // Ready word is queued by event_now in this same cycle
        if (i_powerup_ok) begin
          next_mission = 1'b1;
          next_state = ST_WAIT;
        end
      end
      ST_HOLDOFF: begin
        // Leave room for the other drivers and the host
        if (cnt == '0) begin
          next_state = ST_WAIT;
        end else begin
          next_cnt = cnt - sbr_cnt_t'(1);
        end
      end
      ST_WAIT: begin
        if (pending && (idle_cnt >= sbr_cnt_t'(BUS_IDLE_CYC))) begin
          next_state = ST_ARB;
          next_cnt = slot_cyc;
        end
      end
      ST_ARB: begin
        // Holding the line low for our slot
        if (cnt == '0) begin
          next_state = ST_CHECK;
          next_cnt = sbr_cnt_t'(SETTLE_CYC - 1);
        end else begin
          next_cnt = cnt - sbr_cnt_t'(1);
        end
      end
      ST_CHECK: begin
        // Judged after a short settle so the pull-up can lift the line
        if (cnt != '0) begin
          next_cnt = cnt - sbr_cnt_t'(1);
        end else if (i_line) begin
          next_state = ST_BITHI;
          next_pending = 1'b0;
          next_bit_idx = '0;
          next_cnt = high_cyc(tx_frame[0]);
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_BITHI: begin
        if (cnt == '0) begin
          next_state = ST_BITLO;
          next_cnt = sbr_cnt_t'(BIT_LOW_CYC - 1);
        end else begin
          next_cnt = cnt - sbr_cnt_t'(1);
        end
      end
      ST_BITLO: begin
        if (cnt != '0) begin
          next_cnt = cnt - sbr_cnt_t'(1);
        end else if (bit_idx == LAST_BIT) begin
          // Parity was last; the frame is complete
          next_state = ST_HOLDOFF;
          next_cnt = sbr_cnt_t'(P_HOLDOFF_CYC - 1);
          next_last_frame = tx_frame;
          if (late || event_now) begin
            next_tx_frame = build_frame(i_status);
            next_pending = 1'b1;
            next_late = 1'b0;
          end
        end else begin
          next_state = ST_BITHI;
          next_bit_idx = bit_idx + 3'h1;
          next_cnt = high_cyc(tx_frame[bit_idx + 3'h1]);
        end
      end
      default: begin
        next_state = ST_POWERUP;
      end
    endcase
    // Host clear overrides all: drop queued work, back to power-up
    if (clear_seen) begin
      next_state = ST_POWERUP;
      next_mission = 1'b0;
      next_pending = 1'b0;
      next_late = 1'b0;
      next_clear_pulse = 1'b1;
    end
    next_oe_n = !((next_state == ST_ARB) || (next_state == ST_BITLO));
  end

  // Reporter registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_POWERUP;
      cnt <= '0;
      bit_idx <= '0;
      tx_frame <= '0;
      pending <= 1'b0;
      late <= 1'b0;
      snap <= '0;
      o_mission <= 1'b0;
      o_clear_pulse <= 1'b0;
      o_line_oe_n <= 1'b1;
      o_last_frame <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      tx_frame <= next_tx_frame;
      pending <= next_pending;
      late <= next_late;
      snap <= next_snap;
      o_mission <= next_mission;
      o_clear_pulse <= next_clear_pulse;
      o_line_oe_n <= next_oe_n;
      o_last_frame <= next_last_frame;
    end
  end

  // Checks
  a_parity_odd: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_BITHI) |-> (^tx_frame) == 1'b1)
    else $error("frame parity not odd");
  a_drive_only_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_line_oe_n |-> (o_line_o == 1'b0) && ((state == ST_ARB) || (state == ST_BITLO)))
    else $error("line driven outside arbitration or bit low");
  a_low_length: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_BITHI) ##1 (state == ST_BITLO) |-> cnt == sbr_cnt_t'(BIT_LOW_CYC - 1))
    else $error("bit low interval wrong");
  a_high_length: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state != ST_BITHI) ##1 (state == ST_BITHI) |-> cnt == high_cyc(tx_frame[bit_idx]))
    else $error("bit high interval wrong");
  a_idle_before_try: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_WAIT) ##1 (state == ST_ARB) |-> $past(idle_cnt) >= sbr_cnt_t'(BUS_IDLE_CYC))
    else $error("arbitration without idle bus");
  a_slot_length: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_WAIT) ##1 (state == ST_ARB) |-> (cnt == slot_cyc) && !o_line_oe_n)
    else $error("slot length or drive wrong");
  a_lost_retry: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_CHECK) && (cnt == '0) && !i_line && !clear_seen |=> (state == ST_WAIT))
    else $error("lost arbitration not retried");
  a_holdoff_length: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_BITLO) ##1 (state == ST_HOLDOFF) |-> cnt == sbr_cnt_t'(P_HOLDOFF_CYC - 1))
    else $error("holdoff length wrong");
  a_frame_frozen: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == ST_BITHI) ##1 (state == ST_BITHI || state == ST_BITLO) |-> $stable(tx_frame))
    else $error("frame changed while sending");
  a_clear_return: assert property (@(posedge i_clk) disable iff (!i_rstn)
    clear_seen |=> (state == ST_POWERUP) && !o_mission && o_clear_pulse)
    else $error("clear command not obeyed");

endmodule : sbr_status_reporter

// >>> include/sbr_pkg.sv
// Constants, codes and types of the single-wire status reporter.
// Assumes a 40 MHz core clock; all times are converted to cycles here.
package sbr_pkg;

  // Core clock rate
  localparam int unsigned CLK_MHZ = 40;

  // Times in ns, as specified
  localparam int unsigned T_BIT_LOW_NS = 10000;    // Low part of every bit
  localparam int unsigned T_ONE_HIGH_NS = 40000;   // Released part of a one
  localparam int unsigned T_ZERO_HIGH_NS = 10000;  // Released part of a zero
  localparam int unsigned T_SLOT1_NS = 40000;      // Arbitration slot, identity 1
  localparam int unsigned T_SLOT2_NS = 60000;      // Arbitration slot, identity 2
  localparam int unsigned T_SLOT3_NS = 80000;      // Arbitration slot, identity 3
  localparam int unsigned T_BUS_IDLE_NS = 80000;   // Least idle-high time before a try
  localparam int unsigned T_HOLDOFF_NS = 160000;   // Quiet time after each frame
  localparam int unsigned T_QUERY_NS = 160000;     // Host low pulse: status query
  localparam int unsigned T_CLEAR_NS = 320000;     // Host low pulse: latch clear

  // Least time to cycles, rounded up, never below one
  function automatic int unsigned ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction : ns2cyc

  localparam int unsigned BIT_LOW_CYC = ns2cyc(T_BIT_LOW_NS);
  localparam int unsigned ONE_HIGH_CYC = ns2cyc(T_ONE_HIGH_NS);
  localparam int unsigned ZERO_HIGH_CYC = ns2cyc(T_ZERO_HIGH_NS);
  localparam int unsigned SLOT1_CYC = ns2cyc(T_SLOT1_NS);
  localparam int unsigned SLOT2_CYC = ns2cyc(T_SLOT2_NS);
  localparam int unsigned SLOT3_CYC = ns2cyc(T_SLOT3_NS);
  localparam int unsigned BUS_IDLE_CYC = ns2cyc(T_BUS_IDLE_NS);
  localparam int unsigned HOLDOFF_CYC = ns2cyc(T_HOLDOFF_NS);
  localparam int unsigned QUERY_CYC = ns2cyc(T_QUERY_NS);
  localparam int unsigned CLEAR_CYC = ns2cyc(T_CLEAR_NS);
  // Cycles after release before the line is judged (pull-up rise time)
  localparam int unsigned SETTLE_CYC = 2;

  // Counter width covers the longest count
  localparam int unsigned CNT_W = 14;
  typedef logic [CNT_W-1:0] sbr_cnt_t;

  // Frame layout: seven status bits then parity
  localparam int unsigned WORD_BITS = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // System field codes, written bit0 bit1 bit2 from the left
  localparam logic [2:0] SYS_NONE = 3'h0;
  localparam logic [2:0] SYS_BUS_OV = 3'h1;
  localparam logic [2:0] SYS_UV100 = 3'h2;
  localparam logic [2:0] SYS_UV85 = 3'h3;
  localparam logic [2:0] SYS_UV70 = 3'h4;
  localparam logic [2:0] SYS_UV55 = 3'h5;
  localparam logic [2:0] SYS_EXT_HOT = 3'h6;
  localparam logic [2:0] SYS_LS_NRDY = 3'h7;
  // Device field codes, written bit3 bit4 from the left
  localparam logic [1:0] DEV_NONE = 2'h0;
  localparam logic [1:0] DEV_LS_WARN = 2'h1;
  localparam logic [1:0] DEV_LS_SHUTDOWN = 2'h2;
  localparam logic [1:0] DEV_HS_NRDY = 2'h3;

  // Address-select pin states and the identities they select
  localparam logic [1:0] ADDR_FLOAT = 2'h0;
  localparam logic [1:0] ADDR_LOW_SUPPLY = 2'h1;
  localparam logic [1:0] ADDR_SIG_RETURN = 2'h2;
  localparam logic [1:0] ID_ONE = 2'h1;
  localparam logic [1:0] ID_TWO = 2'h2;
  localparam logic [1:0] ID_THREE = 2'h3;

  // Live fault condition as the protection logic presents it
  typedef struct packed {
    logic [2:0] sys;  // System state code
    logic [1:0] dev;  // Device state code
    logic ls_oc;      // Low-side over-current
    logic hs_oc;      // High-side over-current
  } sbr_status_t;

  // Reporter states
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_HOLDOFF = 3'b001,
    ST_WAIT = 3'b010,
    ST_ARB = 3'b011,
    ST_CHECK = 3'b100,
    ST_BITHI = 3'b101,
    ST_BITLO = 3'b110
  } sbr_state_t;

  // Status to frame: word bit 0 in frame bit 0, odd parity in bit 7
  function automatic logic [7:0] build_frame(input sbr_status_t s);
    logic [6:0] w;
    w = {s.hs_oc, s.ls_oc, s.dev[0], s.dev[1], s.sys[0], s.sys[1], s.sys[2]};
    return {~(^w), w};
  endfunction : build_frame

  // Released-high length of a bit, less one for the down-counter
  function automatic sbr_cnt_t high_cyc(input logic b);
    return b ? sbr_cnt_t'(ONE_HIGH_CYC - 1) : sbr_cnt_t'(ZERO_HIGH_CYC - 1);
  endfunction : high_cyc

endpackage : sbr_pkg

// >>> test/sbr_host_model.sv
// Host microcontroller model on the shared status line, plus a frame decoder.
// Assumes an external pull-up: the line is high unless some party pulls it low.
`timescale 1ns/1ps
module sbr_host_model (
  input wire logic i_clk,
  input wire logic i_oe_n,
  input wire logic i_line_o,
  input wire logic i_go,
  input wire logic [15:0] i_pull_cyc,
  output logic o_line,
  output logic o_frm_vld,
  output logic [7:0] o_frm,
  output logic [15:0] o_arb_len,
  output logic [15:0] o_gap,
  output logic [15:0] o_bad
);
  logic [15:0] pull = 16'h0; // Host low time still to run
  logic [15:0] run = 16'h0; // Length of the present level
  logic [15:0] prev_hi = 16'h0; // Last high run, idle before a slot
  logic [3:0] nb = 4'h0; // Bits decoded so far
  logic infrm = 1'h0; // Inside a frame
  logic last = 1'h1; // Line level at the previous edge
  // Settle time merges into the first released bit
  wire [15:0] hv = run - ((nb == 4'h0) ? 16'h2 : 16'h0);
  // Pull-up supplies high; nobody drives the line high
  assign o_line = (pull != 16'h0) ? 1'h0 : (i_oe_n ? 1'h1 : i_line_o);
  initial begin
    o_frm_vld = 1'h0;
    o_frm = 8'h0;
    o_arb_len = 16'h0;
    o_gap = 16'h0;
    o_bad = 16'h0;
  end
  // Host pulls: query, clear, or a slot outlasting any device
  always @(posedge i_clk) begin
    if (i_go) begin
      pull <= i_pull_cyc;
    end else if (pull != 16'h0) begin
      pull <= pull - 16'h1;
    end
  end
  // Run-length decoder: a long low opens a frame, the high length is the bit
  always @(posedge i_clk) begin
    o_frm_vld <= 1'h0;
    last <= o_line;
    if (o_line == last) begin
      run <= run + 16'h1;
    end else begin
      run <= 16'h1;
      if (o_line && run >= 16'h3E8) begin // Slot over: frame may follow
        infrm <= 1'h1;
        nb <= 4'h0;
        o_arb_len <= run;
        o_gap <= prev_hi;
      end else if (o_line && infrm && run != 16'h190) begin // Bit low off length
        o_bad <= o_bad + 16'h1;
      end else if (!o_line) begin
        prev_hi <= run;
        if (infrm && run > 16'h7D0) begin // Long idle: slot was lost, drop it
          infrm <= 1'h0;
        end else if (infrm) begin
          if (hv != 16'h190 && hv != 16'h640) begin
            o_bad <= o_bad + 16'h1;
          end
          o_frm[nb[2:0]] <= (hv > 16'h3E8);
          nb <= nb + 4'h1;
          if (nb == 4'h7) begin // Eight bits make a frame
            infrm <= 1'h0;
            o_frm_vld <= 1'h1;
          end
        end
      end
    end
  end
endmodule : sbr_host_model

// >>> test/sbr_status_reporter_tb.sv
// Self-checking bench for the status reporter: frames, identities, host commands.
// Assumes the host model resolves the line and decodes every frame it sees.
`timescale 1ns/1ps
module sbr_status_reporter_tb;
  import sbr_pkg::*;
  logic i_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic [1:0] addr = 2'h1; // Strap level
  sbr_status_t st = 7'h0; // Live faults
  logic pwr = 1'h1; // Power-up finished
  logic go = 1'h0;
  logic [15:0] pcyc = 16'h0;
  logic line, oe_n, line_o, mission, clr, busy, fvld;
  logic [7:0] last_frame, frm;
  logic [1:0] dev_id;
  logic [15:0] arb_len, gap, bad;
  int error_cnt = 0;
  int check_count = 0;
  int nfr = 0; // Frames decoded
  int hi;
  int seed = 32'h925DD3DA;
  sbr_status_t a, b;
  // Shortest slot last, so the later frames keep the run short
  logic [1:0] sels [3] = '{2'h2, 2'h0, 2'h1};
  logic [1:0] ids [3] = '{2'h3, 2'h2, 2'h1};
  logic [15:0] slots [3] = '{16'hC80, 16'h960, 16'h640}; // 80, 60, 40 us
  // Free-running 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  // Short command counts; quiet time just outlasts the idle time, so it shows
  sbr_status_reporter #(.P_HOLDOFF_CYC(3400), .P_QUERY_CYC(100), .P_CLEAR_CYC(200)) uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_line(line), .o_line_o(line_o),
    .o_line_oe_n(oe_n), .i_addr_sel(addr), .i_status(st), .i_powerup_ok(pwr),
    .o_mission(mission), .o_clear_pulse(clr), .o_busy(busy),
    .o_last_frame(last_frame), .o_device_id(dev_id));
  sbr_host_model host (
    .i_clk(i_clk), .i_oe_n(oe_n), .i_line_o(line_o), .i_go(go), .i_pull_cyc(pcyc),
    .o_line(line), .o_frm_vld(fvld), .o_frm(frm), .o_arb_len(arb_len), .o_gap(gap),
    .o_bad(bad));
  // Count frames away from the sampling edge
  always @(negedge i_clk) begin
    if (fvld === 1'h1) begin
      nfr++;
    end
  end
  // Word bit 0 leads; parity makes the ones odd
  function automatic logic [7:0] exp_frm(input sbr_status_t s);
    logic [6:0] w;
    w = {s.hs_oc, s.ls_oc, s.dev[0], s.dev[1], s.sys[0], s.sys[1], s.sys[2]};
    return {~(^w), w};
  endfunction : exp_frm
  task automatic tick;
    @(posedge i_clk);
    #2;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (oe_n !== lvl && n < 40000) begin
      tick;
      n++;
    end
    chk({15'h0, oe_n}, {15'h0, lvl});
  endtask : wait_oe
  // Bounded wait for a decoded frame, then compare it
  task automatic wait_frm(input sbr_status_t s);
    int n;
    n = 0;
    while (fvld !== 1'h1 && n < 40000) begin
      tick;
      n++;
    end
    chk({15'h0, fvld}, 16'h1);
    chk({8'h0, frm}, {8'h0, exp_frm(s)});
    chk({15'h0, line_o}, 16'h0);
    chk({15'h0, gap >= 16'hC80}, 16'h1);
    repeat (500) tick;
    chk({8'h0, last_frame}, {8'h0, exp_frm(s)});
    chk({15'h0, busy}, 16'h0);
  endtask : wait_frm
  task automatic pull(input logic [15:0] c);
    go = 1'h1;
    pcyc = c;
    tick;
    go = 1'h0;
  endtask : pull
  task automatic do_reset;
    i_rstn = 1'h0;
    repeat (12) tick;
    i_rstn = 1'h1;
  endtask : do_reset
  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    tick;
    // Each strap: identity, slot length, ready word
    for (int i = 0; i < 3; i++) begin
      addr = sels[i];
      // Few ones per word keep the frames short; masks together cover every bit except ls_oc
      st = (i == 0) ? 7'h0 : sbr_status_t'($random(seed) & ((i == 1) ? 32'h54 : 32'h29));
      do_reset;
      repeat (3) tick;
      chk({14'h0, dev_id}, {14'h0, ids[i]});
      if (i == 2) begin
        wait_oe(1'h0);
        pull(16'h672); // Host outlasts the slot so the device loses
      end
      wait_frm(st);
      chk(arb_len, slots[i]);
      chk({15'h0, mission}, 16'h1);
    end
    // A change, then another while the first is on the wire
    a = sbr_status_t'($random(seed) & 32'h6);
    a.sys = SYS_BUS_OV; // No strap-phase word carries this code
    st = a;
    wait_oe(1'h0);
    chk({15'h0, busy}, 16'h1);
    wait_oe(1'h1);
    repeat (100) tick;
    b = sbr_status_t'($random(seed) & 32'h9);
    b.sys = SYS_UV70;
    st = b;
    wait_frm(a);
    wait_frm(b);
    chk({15'h0, gap >= 16'hD48}, 16'h1); // Quiet time outlasts the idle wait
    // Query answers with current status
    pull(16'h96);
    wait_frm(b);
    // Clear: one pulse, back to power-up until released
    pwr = 1'h0;
    pull(16'h12C);
    hi = 0;
    repeat (320) begin
      tick;
      if (clr === 1'h1) begin
        hi++;
      end
    end
    chk(16'(hi), 16'h1);
    chk({15'h0, mission}, 16'h0);
    pwr = 1'h1;
    wait_frm(b);
    chk(16'(nfr), 16'h7); // Each update sent once
    chk(bad, 16'h0);
    tally_and_finish;
  end
  // Watchdog past the longest run: seven frames of at most three ones each
  initial begin
    repeat (115000) @(posedge i_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule : sbr_status_reporter_tb
